// [test/cis_sampler_tb_top.sv]
// Self-checking bench for the camera input sync sampler
`timescale 1ns/100ps
`include "cis_defines.svh"

module cis_sampler_tb_top;
  `define CHK(a, e, m) begin \
    checks_done++; \
    if ((a) !== (e)) begin \
      err_count++; \
      $display("wrong value at %0t: %s", $time, m); \
    end \
  end

  logic        i_core_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [1:0]  mode;
  logic [2:0]  size;
  logic [15:0] vsw, hsw, hlpf, ppl, pdata, clipm;
  logic        emb, dinv, swap, lpos, sdir, vpol, hpol, ign;
  logic        fmode, fdir, flat, fpol, einv, fvs, lhs, fstat;
  logic        o_vs, vs_oe_n, o_hs, hs_oe_n, o_fld, fld_oe_n, valid, luma;
  wire         pclk, s_vs, s_hs, s_fld;
  wire  [15:0] s_data;
  logic [17:0] q[$];
  logic [17:0] note;
  logic [31:0] rng = 32'hE5EB;
  int          err_count = 0;
  int          checks_done = 0;
  int          ep;

  // Pin level: the device wins when its enable is low
  wire vs_pin = vs_oe_n ? s_vs : o_vs;
  wire hs_pin = hs_oe_n ? s_hs : o_hs;
  wire fld_pin = fld_oe_n ? s_fld : o_fld;

  always #50 i_core_clk = ~i_core_clk;

  cis_sensor_model cis_sensor_model_i (.i_fall(einv), .i_drive_sync(!sdir),
    .i_drive_fld(!(fmode && fdir)), .o_pix_clk(pclk), .o_data(s_data),
    .o_vs(s_vs), .o_hs(s_hs), .o_fld(s_fld));

  cis_sampler cis_sampler_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_pix_clk(pclk), .i_image_data_bus(s_data), .i_vertical_sync(vs_pin),
    .o_vertical_sync(o_vs), .o_vertical_sync_oe_n(vs_oe_n),
    .i_horizontal_sync(hs_pin), .o_horizontal_sync(o_hs),
    .o_horizontal_sync_oe_n(hs_oe_n), .i_field_id(fld_pin),
    .o_field_id(o_fld), .o_field_id_oe_n(fld_oe_n), .i_input_mode_sel(mode),
    .i_embedded_sync_en(emb), .i_data_invert(dinv), .i_raw_sample_size(size),
    .i_luma_chroma_swap(swap), .i_luma_pos_8bit(lpos),
    .i_sync_direction(sdir), .i_vsync_width(vsw), .i_hsync_width(hsw),
    .i_half_lines_per_frame(hlpf), .i_pixels_per_line(ppl),
    .i_vsync_polarity(vpol), .i_hsync_polarity(hpol),
    .i_field_mode_en(fmode), .i_field_direction(fdir),
    .i_field_latch_mode(flat), .i_field_polarity(fpol),
    .i_pixclk_edge_invert(einv), .o_pix_valid(valid), .o_pix_data(pdata),
    .o_luma_flag(luma), .o_raw_clip_max(clipm), .o_frame_vsync(fvs),
    .o_line_hsync(lhs), .o_field_status(fstat));

  always @(posedge i_core_clk) begin
    if (valid === 1'b1 && !ign) begin
      if (q.size() == 0) begin
        `CHK(1'b1, 1'b0, "word without a capture")
      end else begin
        note = q.pop_front();
        `CHK(pdata, note[15:0], "pixel data")
        if (note[17]) `CHK(luma, note[16], "luma flag")
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic pick(input int k);
    return k == 0 ? hs_pin ^ hpol : k == 1 ? vs_pin ^ vpol : fld_pin;
  endfunction : pick

  // Notes the expected word, then lets the sensor present it
  task automatic send(input logic [15:0] w, input logic vs, hs, fd, ex);
    logic [15:0] d;
    logic [17:0] n;
    int          k;
    d = w ^ {16{dinv}};
    n = {2'b10, d >> size};
    if (mode == `CIS_MODE_YUV16)
      n = {2'b11, swap ? {d[7:0], d[15:8]} : d};
    if (mode == `CIS_MODE_YUV8)
      n = {ep >= 0, ep == lpos, 8'h00, swap ? d[15:8] : d[7:0]};
    if (mode == `CIS_MODE_YUV8)
      ep = (hs ^ hpol) ? 0 : (ep < 0 ? -1 : 1 - ep);
    if (ex)
      q.push_back(n);
    cis_sensor_model_i.burst(w, vs, hs, fd);
    for (k = 0; k < 12 && (q.size() != 0 || !ex); k++) @(negedge i_core_clk);
    `CHK(q.size(), 0, "word not delivered")
    repeat (4) @(negedge i_core_clk);
  endtask : send

  // Edge swap may make one stray capture, so that word is ignored
  task automatic set_edge(input logic e);
    einv = e;
    ign = 1'b1;
    send(16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
    ign = 1'b0;
  endtask : set_edge

  task automatic measure(input int k, input int hi, input int per);
    int n;
    int h;
    for (n = 0; n < 99 && pick(k) !== 1'b0; n++) @(negedge i_core_clk);
    for (n = 0; n < 99 && pick(k) !== 1'b1; n++) @(negedge i_core_clk);
    if (k < 2) `CHK(k ? fvs : lhs, 1'b1, "sync state")
    for (h = 0; h < 99 && pick(k) === 1'b1; h++) @(negedge i_core_clk);
    for (n = h; n < 99 && pick(k) !== 1'b1; n++) @(negedge i_core_clk);
    `CHK(h, hi, "sync active length")
    `CHK(n, per, "sync period")
  endtask : measure

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    {mode, size, emb, dinv, swap, lpos, einv, ign} = '0;
    {sdir, vpol, hpol, fmode, fdir, flat, fpol} = '0;
    {vsw, hsw, hlpf, ppl} = {16'h0002, 16'h0003, 16'h0004, 16'h000A};
    ep = -1;
    fork
      cis_sensor_model_i.burst(16'h0000, 1'b0, 1'b0, 1'b0);
    join_none
    repeat (6) @(negedge i_core_clk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_core_clk);
    for (int i = 0; i < 16; i++) begin
      {dinv, size} = i[3:0];
      repeat (2) @(negedge i_core_clk);
      `CHK(clipm, 16'hFFFF >> size, "clip limit")
      rng = xs(rng);
      send(rng[15:0], 1'b0, 1'b0, 1'b0, 1'b1);
    end
    `CHK({fld_oe_n, fstat, vs_oe_n}, 3'b101, "field off")
    $display("raw capture done");
    set_edge(1'b1);
    for (int i = 0; i < 8; i++) begin
      {emb, dinv, swap} = i[2:0];
      mode = `CIS_MODE_YUV16;
      rng = xs(rng);
      send(rng[15:0], 1'b0, 1'b0, 1'b0, 1'b1);
      mode = 2'h3;
      send(rng[15:0], 1'b0, 1'b0, 1'b0, 1'b0);
      {mode, emb} = 3'b001;
      send(rng[15:0], 1'b0, 1'b0, 1'b0, 1'b0);
    end
    $display("wide capture done");
    set_edge(1'b0);
    {mode, emb} = {`CIS_MODE_YUV8, 1'b0};
    ep = -1;
    for (int i = 0; i < 32; i++) begin
      {hpol, lpos, swap} = i[4:2];
      rng = xs(rng);
      send(rng[15:0], 1'b0, (i[1:0] == 0) ^ hpol, 1'b0, 1'b1);
      `CHK(lhs, i[1:0] == 0, "hsync state")
    end
    $display("narrow capture done");
    {mode, fmode, hpol} = 4'b0010;
    for (int i = 0; i < 16; i++) begin
      {flat, fpol} = i[3:2];
      rng = xs(rng);
      send(rng[15:0], !i[0], 1'b0, (i[0] == i[1]) ^ fpol, 1'b1);
      `CHK(fstat, flat ? !i[1] : i[0] == i[1], "field")
      `CHK(fvs, !i[0], "vsync state")
    end
    $display("field input done");
    {mode, fdir, sdir} = 4'b1111;
    for (int i = 0; i < 2; i++) begin
      {hpol, vpol} = {i[0], ~i[0]};
      repeat (3) @(negedge i_core_clk);
      `CHK({vs_oe_n, hs_oe_n, fld_oe_n}, 3'b000, "enables")
      measure(0, 3, 10);
      measure(1, 10, 20);
      measure(2, 20, 40);
    end
    $display("sync generation done");
    tally_and_finish();
  end
endmodule : cis_sampler_tb_top

// [test/cis_sensor_model.sv]
// Image sensor model: pixel clock, data bus and sync pins in bursts
`timescale 1ns/100ps

module cis_sensor_model (
  input  wire logic  i_fall,
  input  wire logic  i_drive_sync,
  input  wire logic  i_drive_fld,
  output logic       o_pix_clk,
  output logic [15:0] o_data,
  output logic       o_vs,
  output logic       o_hs,
  output logic       o_fld
);
  logic vs_r;
  logic hs_r;
  logic fld_r;

  initial begin
    o_pix_clk = 1'b0;
    o_data = 16'h0000;
    {vs_r, hs_r, fld_r} = 3'h0;
  end

  // Released pins show the inverse, so a stale level never passes
  assign o_vs = i_drive_sync ? vs_r : ~vs_r;
  assign o_hs = i_drive_sync ? hs_r : ~hs_r;
  assign o_fld = i_drive_fld ? fld_r : ~fld_r;

  // Clock runs only within a burst; 48 ns period stays legal
  // Data is right only at the chosen edge, inverted at the other
  task automatic burst(input logic [15:0] w, input logic vs, hs, fd);
    vs_r = vs;
    hs_r = hs;
    fld_r = fd;
    repeat (6) begin
      #6 o_data = i_fall ? ~w : w;
      #18 o_pix_clk = 1'b1;
      #6 o_data = i_fall ? w : ~w;
      #18 o_pix_clk = 1'b0;
    end
  endtask : burst
endmodule : cis_sensor_model

// [verilog/cis_defines.svh]
// Constants for the camera input sync sampler
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH

`define CIS_DATA_W          16
`define CIS_CNT_W           16
`define CIS_SIZE_W          3

`define CIS_MODE_RAW        2'h0
`define CIS_MODE_YUV16      2'h1
`define CIS_MODE_YUV8       2'h2

`define CIS_LUMA_HI         15
`define CIS_LUMA_LO         8
`define CIS_CHROMA_HI       7
`define CIS_CHROMA_LO       0

`define CIS_DATA_RST        16'h0000
`define CIS_CNT_RST         16'h0000
`define CIS_CLIP_RST        16'hFFFF
`define CIS_PIN_RST         1'b0
`define CIS_OE_N_RST        1'b1

`define CIS_CORE_PERIOD_NS  100
`define CIS_PCLK_MARGIN_NS  1
`define CIS_PCLK_MAX_NS     (2 * `CIS_CORE_PERIOD_NS + `CIS_PCLK_MARGIN_NS)

`endif

// [verilog/cis_pix_capture.sv]
// Pixel clock domain capture and request side of the word handshake
`timescale 1ns/100ps
`include "cis_defines.svh"

module cis_pix_capture #(
  parameter int DATA_W = `CIS_DATA_W
) (
  input  wire logic              i_pix_clk,
  input  wire logic              i_rstn,
  input  wire logic [DATA_W-1:0] i_image_data_bus,
  input  wire logic              i_vertical_sync,
  input  wire logic              i_horizontal_sync,
  input  wire logic              i_field_id,
  input  wire logic              i_ack,
  output logic                   o_req,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_vsync,
  output logic                   o_hsync,
  output logic                   o_field
);

  // Byte lane slicing downstream assumes the full bus width
  if (DATA_W != `CIS_DATA_W) begin : g_bad_width
    $error("cis_pix_capture: DATA_W must match the bus width");
  end

  cis_pkg::cis_pix_t st;
  cis_pkg::cis_pix_t next_st;
  logic              ack_s;

  cis_sync2 u_ack_sync (
    .i_clk   (i_pix_clk),
    .i_rstn  (i_rstn),
    .i_async (i_ack),
    .o_sync  (ack_s)
  );

  // Hold word stays frozen until the core acknowledges; samples that
  // arrive meanwhile are dropped rather than tearing the held word
  always_comb begin
    next_st = st;
    if (ack_s == st.req) begin
      next_st.hold_data = i_image_data_bus;
      next_st.hold_vs   = i_vertical_sync;
      next_st.hold_hs   = i_horizontal_sync;
      next_st.hold_fld  = i_field_id;
      next_st.req       = ~st.req;
    end
  end

  always_ff @(posedge i_pix_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_req   = st.req;
  assign o_data  = st.hold_data;
  assign o_vsync = st.hold_vs;
  assign o_hsync = st.hold_hs;
  assign o_field = st.hold_fld;

endmodule : cis_pix_capture

// [verilog/cis_pkg.sv]
// Types for the camera input sync sampler
`include "cis_defines.svh"

package cis_pkg;

  typedef enum logic [2:0] {
    CIS_FMT_RAW,
    CIS_FMT_YUV16,
    CIS_FMT_YUV8,
    CIS_FMT_EMBED,
    CIS_FMT_OFF
  } cis_fmt_t;

  typedef struct packed {
    logic meta;
    logic sync;
  } cis_sync_t;

  typedef struct packed {
    logic [`CIS_DATA_W-1:0] hold_data;
    logic                   hold_vs;
    logic                   hold_hs;
    logic                   hold_fld;
    logic                   req;
  } cis_pix_t;

  typedef struct packed {
    logic                   req_seen;
    logic                   rx_vs;
    logic                   rx_hs;
    logic                   fld_in;
    logic                   fld_lat;
    logic                   parity;
    logic                   valid;
    logic [`CIS_DATA_W-1:0] data;
    logic                   luma_flag;
    logic [`CIS_DATA_W-1:0] clip_max;
    logic [`CIS_CNT_W-1:0]  hcnt;
    logic [`CIS_CNT_W-1:0]  hlcnt;
    logic                   gen_fld;
    logic                   vs_act;
    logic                   hs_act;
    logic                   vs_pin;
    logic                   hs_pin;
    logic                   fld_pin;
    logic                   sync_oe_n;
    logic                   fld_oe_n;
    logic                   frame_vsync;
    logic                   line_hsync;
    logic                   field_status;
  } cis_core_t;

endpackage : cis_pkg

// [verilog/cis_sampler.sv]
// Camera input sync sampler: capture, formatting and sync generation
//
// Contract
// - YUV mode takes 8-bit or 16-bit data, chosen by input mode field.
// - Input mode field, not embedded-sync enable, selects YUV capture.
// - Data invert set flips every data bit; clear passes data unchanged.
// - 16-bit YUV: swap control exchanges luma and chroma byte lanes.
// - 8-bit YUV: swap control picks lower or upper bus half.
// - 8-bit YUV: luma position control picks even or odd samples as luma.
// - One direction control makes both sync pins inputs or outputs.
// - Generated vertical sync uses programmed width and half lines.
// - Generated horizontal sync uses programmed width and pixels per line.
// - Vertical and horizontal sync polarity reverse independently.
// - Field signal used only in field mode; direction control sets it.
// - Field input with latch mode is captured at the vertical sync event.
// - Field polarity control reverses the field signal.
// - Pixel clock edge control picks rising or falling sampling edge.
// - Raw capture only when mode field zero and embedded sync disabled.
// - Raw mode latches data on pixel clock and bypasses YUV stage.
// - Raw samples shift right by size code; size bounds clipping.
`timescale 1ns/100ps
`include "cis_defines.svh"

module cis_sampler (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_pix_clk,
  input  wire logic [`CIS_DATA_W-1:0] i_image_data_bus,
  input  wire logic                   i_vertical_sync,
  output logic                        o_vertical_sync,
  output logic                        o_vertical_sync_oe_n,
  input  wire logic                   i_horizontal_sync,
  output logic                        o_horizontal_sync,
  output logic                        o_horizontal_sync_oe_n,
  input  wire logic                   i_field_id,
  output logic                        o_field_id,
  output logic                        o_field_id_oe_n,
  input  wire logic [1:0]             i_input_mode_sel,
  input  wire logic                   i_embedded_sync_en,
  input  wire logic                   i_data_invert,
  input  wire logic [`CIS_SIZE_W-1:0] i_raw_sample_size,
  input  wire logic                   i_luma_chroma_swap,
  input  wire logic                   i_luma_pos_8bit,
  input  wire logic                   i_sync_direction,
  input  wire logic [`CIS_CNT_W-1:0]  i_vsync_width,
  input  wire logic [`CIS_CNT_W-1:0]  i_hsync_width,
  input  wire logic [`CIS_CNT_W-1:0]  i_half_lines_per_frame,
  input  wire logic [`CIS_CNT_W-1:0]  i_pixels_per_line,
  input  wire logic                   i_vsync_polarity,
  input  wire logic                   i_hsync_polarity,
  input  wire logic                   i_field_mode_en,
  input  wire logic                   i_field_direction,
  input  wire logic                   i_field_latch_mode,
  input  wire logic                   i_field_polarity,
  input  wire logic                   i_pixclk_edge_invert,
  output logic                        o_pix_valid,
  output logic      [`CIS_DATA_W-1:0] o_pix_data,
  output logic                        o_luma_flag,
  output logic      [`CIS_DATA_W-1:0] o_raw_clip_max,
  output logic                        o_frame_vsync,
  output logic                        o_line_hsync,
  output logic                        o_field_status
);

  cis_pkg::cis_core_t         st;
  cis_pkg::cis_core_t         next_st;
  cis_pkg::cis_fmt_t          fmt;
  logic                       pix_clk_sel;
  logic                       req_s;
  logic                       pix_req;
  logic                       take;
  logic [`CIS_DATA_W-1:0]     pix_data;
  logic                       pix_vs;
  logic                       pix_hs;
  logic                       pix_fld;
  logic [`CIS_DATA_W-1:0]     inv_data;
  logic                       rx_vs;
  logic                       rx_hs;
  logic                       rx_fld;
  logic                       half_step;
  logic                       next_vs_act;
  logic                       next_hs_act;

  // Edge select is a clock mux; change it only while the link is idle
  assign pix_clk_sel = i_pix_clk ^ i_pixclk_edge_invert;

  cis_pix_capture #(
    .DATA_W (`CIS_DATA_W)
  ) u_pix (
    .i_pix_clk         (pix_clk_sel),
    .i_rstn            (i_rstn),
    .i_image_data_bus  (i_image_data_bus),
    .i_vertical_sync   (i_vertical_sync),
    .i_horizontal_sync (i_horizontal_sync),
    .i_field_id        (i_field_id),
    .i_ack             (st.req_seen),
    .o_req             (pix_req),
    .o_data            (pix_data),
    .o_vsync           (pix_vs),
    .o_hsync           (pix_hs),
    .o_field           (pix_fld)
  );

  cis_sync2 u_req_sync (
    .i_clk   (i_core_clk),
    .i_rstn  (i_rstn),
    .i_async (pix_req),
    .o_sync  (req_s)
  );

  // Held word is stable from request toggle until our acknowledge
  assign take     = req_s ^ st.req_seen;
  assign inv_data = pix_data ^ {`CIS_DATA_W{i_data_invert}};
  assign rx_vs    = pix_vs ^ i_vsync_polarity;
  assign rx_hs    = pix_hs ^ i_hsync_polarity;
  assign rx_fld   = pix_fld ^ i_field_polarity;

  always_comb begin
    unique case (i_input_mode_sel)
      `CIS_MODE_RAW: begin
        fmt = i_embedded_sync_en ? cis_pkg::CIS_FMT_EMBED
                                 : cis_pkg::CIS_FMT_RAW;
      end
      `CIS_MODE_YUV16: begin
        fmt = cis_pkg::CIS_FMT_YUV16;
      end
      `CIS_MODE_YUV8: begin
        fmt = cis_pkg::CIS_FMT_YUV8;
      end
      default: begin
        fmt = cis_pkg::CIS_FMT_OFF;
      end
    endcase
  end

  // Sync generator counters, one pixel per core cycle
  assign half_step   = (st.hcnt == '0) ||
                       (st.hcnt == (i_pixels_per_line >> 1));
  assign next_vs_act = i_sync_direction && (st.hlcnt < i_vsync_width);
  assign next_hs_act = i_sync_direction && (st.hcnt < i_hsync_width);

  always_comb begin
    next_st          = st;
    next_st.valid    = 1'b0;
    next_st.clip_max = `CIS_CLIP_RST >> i_raw_sample_size;
    if (take) begin
      next_st.req_seen = req_s;
      next_st.rx_vs    = rx_vs;
      next_st.rx_hs    = rx_hs;
      next_st.fld_in   = rx_fld;
      if (i_field_latch_mode && rx_vs && !st.rx_vs) begin
        next_st.fld_lat = rx_fld;
      end
      next_st.parity = rx_hs ? 1'b0 : ~st.parity;
      unique case (fmt)
        cis_pkg::CIS_FMT_RAW: begin
          next_st.valid     = 1'b1;
          next_st.data      = inv_data >> i_raw_sample_size;
          next_st.luma_flag = 1'b0;
        end
        cis_pkg::CIS_FMT_YUV16: begin
          next_st.valid     = 1'b1;
          next_st.luma_flag = 1'b1;
          if (i_luma_chroma_swap) begin
            next_st.data = {inv_data[`CIS_CHROMA_HI:`CIS_CHROMA_LO],
                            inv_data[`CIS_LUMA_HI:`CIS_LUMA_LO]};
          end else begin
            next_st.data = inv_data;
          end
        end
        cis_pkg::CIS_FMT_YUV8: begin
          next_st.valid     = 1'b1;
          next_st.luma_flag = (st.parity == i_luma_pos_8bit);
          next_st.data      = {8'h00, i_luma_chroma_swap
                               ? inv_data[`CIS_LUMA_HI:`CIS_LUMA_LO]
                               : inv_data[`CIS_CHROMA_HI:`CIS_CHROMA_LO]};
        end
        cis_pkg::CIS_FMT_EMBED, cis_pkg::CIS_FMT_OFF: begin
          next_st.valid = 1'b0;
        end
      endcase
    end
    // Generated timing; zero sizes simply hold the counters at zero
    if (!i_sync_direction) begin
      next_st.hcnt  = '0;
      next_st.hlcnt = '0;
    end else begin
      if ((st.hcnt + 1'b1) >= i_pixels_per_line) begin
        next_st.hcnt = '0;
      end else begin
        next_st.hcnt = `CIS_CNT_W'(st.hcnt + 1'b1);
      end
      if (half_step) begin
        if ((st.hlcnt + 1'b1) >= i_half_lines_per_frame) begin
          next_st.hlcnt   = '0;
          next_st.gen_fld = ~st.gen_fld;
        end else begin
          next_st.hlcnt = `CIS_CNT_W'(st.hlcnt + 1'b1);
        end
      end
    end
    next_st.vs_act    = next_vs_act;
    next_st.hs_act    = next_hs_act;
    next_st.vs_pin    = next_vs_act ^ i_vsync_polarity;
    next_st.hs_pin    = next_hs_act ^ i_hsync_polarity;
    next_st.fld_pin   = st.gen_fld ^ i_field_polarity;
    next_st.sync_oe_n = ~i_sync_direction;
    next_st.fld_oe_n  = ~(i_field_mode_en & i_field_direction);
    next_st.frame_vsync = i_sync_direction ? next_vs_act : st.rx_vs;
    next_st.line_hsync  = i_sync_direction ? next_hs_act : st.rx_hs;
    if (!i_field_mode_en) begin
      next_st.field_status = 1'b0;
    end else if (i_field_direction) begin
      next_st.field_status = st.gen_fld;
    end else begin
      next_st.field_status = i_field_latch_mode ? st.fld_lat
                                                : st.fld_in;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st           <= '0;
      st.clip_max  <= `CIS_CLIP_RST;
      st.sync_oe_n <= `CIS_OE_N_RST;
      st.fld_oe_n  <= `CIS_OE_N_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_vertical_sync        = st.vs_pin;
  assign o_vertical_sync_oe_n   = st.sync_oe_n;
  assign o_horizontal_sync      = st.hs_pin;
  assign o_horizontal_sync_oe_n = st.sync_oe_n;
  assign o_field_id             = st.fld_pin;
  assign o_field_id_oe_n        = st.fld_oe_n;
  assign o_pix_valid            = st.valid;
  assign o_pix_data             = st.data;
  assign o_luma_flag            = st.luma_flag;
  assign o_raw_clip_max         = st.clip_max;
  assign o_frame_vsync          = st.frame_vsync;
  assign o_line_hsync           = st.line_hsync;
  assign o_field_status         = st.field_status;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  a_raw_shift: assert property (
    (take && fmt == cis_pkg::CIS_FMT_RAW) |=> o_pix_valid &&
    o_pix_data == ($past(inv_data) >> $past(i_raw_sample_size)))
    else $error("raw sample not right aligned");

  a_data_invert: assert property (
    (take && fmt == cis_pkg::CIS_FMT_RAW && i_raw_sample_size == 3'h0)
    |=> o_pix_data == ($past(pix_data) ^ {16{$past(i_data_invert)}}))
    else $error("data inversion wrong");

  a_yuv16_swap: assert property (
    (take && fmt == cis_pkg::CIS_FMT_YUV16 && i_luma_chroma_swap)
    |=> o_pix_data[15:8] == $past(inv_data[7:0]))
    else $error("luma chroma lanes not swapped");

  a_yuv8_lane: assert property (
    (take && fmt == cis_pkg::CIS_FMT_YUV8 && !i_luma_chroma_swap)
    |=> o_pix_data == {8'h00, $past(inv_data[7:0])})
    else $error("8-bit lane select wrong");

  a_embed_idle: assert property (
    (take && i_input_mode_sel == 2'h0 && i_embedded_sync_en)
    |=> !o_pix_valid)
    else $error("raw capture while embedded sync on");

  a_sync_dir: assert property (
    $changed(i_sync_direction) |=> ##1
    (o_vertical_sync_oe_n == !$past(i_sync_direction, 2)) &&
    (o_horizontal_sync_oe_n == o_vertical_sync_oe_n))
    else $error("sync pin directions differ");

  a_hsync_start: assert property (
    (i_sync_direction && st.hcnt == 16'h0000 && i_hsync_width != 16'h0000)
    |=> st.hs_act && o_horizontal_sync == !$past(i_hsync_polarity))
    else $error("generated hsync missing at line start");

  a_vsync_pol: assert property (
    $stable(i_vsync_polarity) |=>
    o_vertical_sync == (st.vs_act ^ $past(i_vsync_polarity)))
    else $error("vsync polarity wrong");

  a_field_off: assert property (
    !i_field_mode_en ##1 !i_field_mode_en |=> !o_field_status &&
    o_field_id_oe_n)
    else $error("field used outside field mode");

  a_field_latch: assert property (
    !(take && rx_vs && !st.rx_vs) |=> $stable(st.fld_lat))
    else $error("field latch moved without vsync event");

  a_cdc_ack: assert property (
    take |=> (st.req_seen == $past(req_s)) && !take)
    else $error("handshake acknowledge wrong");

  c_raw_sample: cover property (o_pix_valid && !o_luma_flag &&
                                i_input_mode_sel == 2'h0);
  c_yuv8_luma: cover property (o_pix_valid && o_luma_flag &&
                               i_input_mode_sel == 2'h2);
  c_vsync_gen: cover property (i_sync_direction && $rose(st.vs_act));
  c_field_lat: cover property (take && rx_vs && !st.rx_vs &&
                               i_field_latch_mode);

endmodule : cis_sampler

// [verilog/cis_sync2.sv]
// Two-flop level synchroniser
`timescale 1ns/100ps

module cis_sync2 (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output logic      o_sync
);

  cis_pkg::cis_sync_t st;
  cis_pkg::cis_sync_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st      = st;
    next_st.meta = i_async;
    next_st.sync = st.meta;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.sync;

endmodule : cis_sync2
